/* File: rtl/pwr_mode_ctrl.sv */
// operating mode controller and rail sequencer with apb registers
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps

// Summary of operation
// - exactly one of sleep, standby, active is current at any time
// - in sleep registers stay at defaults and bus accesses are refused
// - wake input low always leads to sleep
// - standby when wake high with all pins low, or standby command
// - any fault forces standby
// - active reported only with a rail on and no fault
// - in active a pin fall disables, a pin rise enables its rail
// - wake rise with a pin high goes active with programmed order
// - wake rise with all pins low enters standby, rails stay off
// - wake fall in active powers down in reverse order, then sleep
// - pins all low with wake high: rails off as pins fell, standby
// - fault or standby command powers rails down in reverse order
// - standby with wake high: pin rise goes active in pin order
// - active command in standby powers up in programmed order
// - wake fall with no rail on goes straight to sleep
// - pin activity ignored while the power-up sequence runs
// - direct wake to active waits the start delay first
module pwr_mode_ctrl
    import pwr_mode_pkg::*;
#(
    parameter int WAKE_DELAY = WAKE_DELAY_CYCLES,
    parameter int DLY_UNIT   = DLY_UNIT_CYCLES
) (
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic        i_wake_input,
    input  wire logic [3:0]  i_rail_enable_pins,
    input  wire fault_s      i_fault,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic [3:0]       o_rail_on,
    output logic [1:0]       o_mode,
    output logic             o_irq
);

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [3:0] slot_rails(input logic [7:0] ord,
                                              input logic [1:0] slot);
        logic [3:0] m;
        m = 4'h0;
        for (int r = 0; r < 4; r++) begin
            m[r] = (ord[2*r +: 2] == slot);
        end
        return m;
    endfunction

    function automatic logic [TIMER_W-1:0] step_delay(
        input logic [7:0] dly);
        return TIMER_W'(int'(dly) * DLY_UNIT);
    endfunction

    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] sync_prev;

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            sync1     <= 6'h00;
            sync2     <= 6'h00;
            sync_prev <= 6'h00;
        end else begin
            sync1     <= {i_fault != 4'h0, i_wake_input,
                          i_rail_enable_pins};
            sync2     <= sync1;
            sync_prev <= sync2;
        end
    end

    logic       wake;
    logic       wake_rise;
    logic       fault;
    logic [3:0] pins;
    logic [3:0] pin_rise;
    logic [3:0] pin_fall;

    assign wake      = sync2[4];
    assign fault     = sync2[5];
    assign pins      = sync2[3:0];
    assign wake_rise = wake & ~sync_prev[4];
    assign pin_rise  = pins & ~sync_prev[3:0];
    assign pin_fall  = ~pins & sync_prev[3:0];

    // ---------------------------------------------------------------
    // sequencer state
    // ---------------------------------------------------------------
    mode_e              mode;
    mode_e              next_mode;
    seq_e               seq;
    seq_e               next_seq;
    logic [1:0]         slot;
    logic [1:0]         next_slot;
    logic [TIMER_W-1:0] timer;
    logic [TIMER_W-1:0] next_timer;
    logic [3:0]         rails;
    logic [3:0]         next_rails;
    logic               to_sleep;
    logic               next_to_sleep;
    logic               ev_up;
    logic               ev_down;
    logic               fault_prev;
    logic               cmd_stby;
    logic               cmd_act;
    logic [7:0]         seq_ord;
    logic [7:0]         seq_dly;

    always_comb begin
        next_mode     = mode;
        next_seq      = seq;
        next_slot     = slot;
        next_timer    = (timer != '0) ? timer - 1'b1 : timer;
        next_rails    = rails;
        next_to_sleep = to_sleep;
        ev_up         = 1'b0;
        ev_down       = 1'b0;
        // a running power-down towards sleep falls through to its stepper
        if (!wake && !(seq == SEQ_DOWN && to_sleep)) begin
            if (rails == 4'h0) begin
                next_mode = MODE_SLEEP;
                next_seq  = SEQ_IDLE;
            end else begin
                next_seq      = SEQ_DOWN;
                next_slot     = 2'd3;
                next_timer    = '0;
                next_to_sleep = 1'b1;
            end
        end else if (mode == MODE_SLEEP) begin
            if (wake_rise && pins != 4'h0 && !fault) begin
                next_mode  = MODE_ACTIVE;
                next_seq   = SEQ_WAIT;
                next_timer = TIMER_W'(WAKE_DELAY);
            end else if (wake_rise) begin
                next_mode = MODE_STANDBY;
            end
        end else if ((fault || cmd_stby) && rails != 4'h0
                     && seq != SEQ_DOWN) begin
            next_seq      = SEQ_DOWN;
            next_slot     = 2'd3;
            next_timer    = '0;
            next_to_sleep = 1'b0;
        end else if ((fault || cmd_stby) && rails == 4'h0) begin
            next_mode = MODE_STANDBY;
            next_seq  = SEQ_IDLE;
        end else if (seq == SEQ_WAIT) begin
            if (timer == '0) begin
                next_seq  = SEQ_UP;
                next_slot = 2'd0;
            end
        end else if (seq == SEQ_UP) begin
            if (timer == '0) begin
                next_rails = rails | slot_rails(seq_ord, slot);
                next_timer = step_delay(seq_dly);
                next_slot  = slot + 2'd1;
                if (slot == 2'd3) begin
                    next_seq = SEQ_IDLE;
                    ev_up    = 1'b1;
                end
            end
        end else if (seq == SEQ_DOWN) begin
            if (timer == '0) begin
                next_rails = rails & ~slot_rails(seq_ord, slot);
                next_timer = step_delay(seq_dly);
                next_slot  = slot - 2'd1;
                if (slot == 2'd0) begin
                    next_seq  = SEQ_IDLE;
                    ev_down   = 1'b1;
                    next_mode = to_sleep ? MODE_SLEEP : MODE_STANDBY;
                end
            end
        end else if (mode == MODE_STANDBY) begin
            if (pin_rise != 4'h0) begin
                next_mode  = MODE_ACTIVE;
                next_rails = pin_rise;
            end else if (cmd_act) begin
                next_mode = MODE_ACTIVE;
                next_seq  = SEQ_UP;
                next_slot = 2'd0;
            end
        end else begin
            next_rails = (rails & ~pin_fall) | pin_rise;
            if (next_rails == 4'h0) begin
                next_mode = MODE_STANDBY;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            mode       <= MODE_SLEEP;
            seq        <= SEQ_IDLE;
            slot       <= 2'd0;
            timer      <= '0;
            rails      <= 4'h0;
            to_sleep   <= 1'b0;
            fault_prev <= 1'b0;
        end else begin
            mode       <= next_mode;
            seq        <= next_seq;
            slot       <= next_slot;
            timer      <= next_timer;
            rails      <= next_rails;
            to_sleep   <= next_to_sleep;
            fault_prev <= fault;
        end
    end

    // ---------------------------------------------------------------
    // apb registers and interrupt
    // ---------------------------------------------------------------
    logic                 bus_on;
    logic                 acc;
    logic                 wr;
    logic                 mapped;
    logic [31:0]          rdata;
    logic [INT_WIDTH-1:0] int_stat;
    logic [INT_WIDTH-1:0] int_mask;
    logic [INT_WIDTH-1:0] int_set;
    logic [INT_WIDTH-1:0] next_int_stat;
    logic [INT_WIDTH-1:0] next_int_mask;
    logic [7:0]           next_seq_ord;
    logic [7:0]           next_seq_dly;
    logic                 next_cmd_stby;
    logic                 next_cmd_act;
    logic                 next_pready;
    logic                 next_pslverr;
    logic [31:0]          next_prdata;
    mode_e                rep_mode;

    assign bus_on = (mode != MODE_SLEEP);
    assign acc    = psel & penable & pready;
    assign wr     = acc & pwrite & bus_on & mapped;

    always_comb begin
        mapped = 1'b1;
        rdata  = 32'h0000_0000;
        case (paddr)
            ADDR_CTRL:     rdata = 32'h0000_0000;
            ADDR_SEQ_ORD:  rdata = {24'h00_0000, seq_ord};
            ADDR_SEQ_DLY:  rdata = {24'h00_0000, seq_dly};
            ADDR_STATUS:   rdata = {17'h0_0000, sync2[5], seq, slot,
                                    rails, pins, o_mode};
            ADDR_INT_STAT: rdata = {29'h0000_0000, int_stat};
            ADDR_INT_MASK: rdata = {29'h0000_0000, int_mask};
            default:       mapped = 1'b0;
        endcase
    end

    always_comb begin
        int_set = '0;
        int_set[INT_FAULT_BIT] = fault & ~fault_prev;
        int_set[INT_UP_BIT]    = ev_up;
        int_set[INT_DOWN_BIT]  = ev_down;
        next_int_stat = int_stat;
        next_int_mask = int_mask;
        next_seq_ord  = seq_ord;
        next_seq_dly  = seq_dly;
        next_cmd_stby = 1'b0;
        next_cmd_act  = 1'b0;
        if (wr) begin
            case (paddr)
                ADDR_CTRL: begin
                    next_cmd_stby = pwdata[CTRL_STANDBY_BIT];
                    next_cmd_act  = pwdata[CTRL_ACTIVE_BIT];
                end
                ADDR_SEQ_ORD:  next_seq_ord  = pwdata[7:0];
                ADDR_SEQ_DLY:  next_seq_dly  = pwdata[7:0];
                ADDR_INT_STAT: next_int_stat =
                                   int_stat & ~pwdata[INT_WIDTH-1:0];
                ADDR_INT_MASK: next_int_mask = pwdata[INT_WIDTH-1:0];
                default:       next_int_mask = int_mask;
            endcase
        end
        // set wins over a clear in the same cycle
        next_int_stat = next_int_stat | int_set;
        if (!bus_on) begin
            next_seq_ord  = SEQ_ORD_RESET;
            next_seq_dly  = SEQ_DLY_RESET;
            next_int_mask = INT_MASK_RESET;
            next_int_stat = '0;
        end
        next_pready  = psel & penable & ~pready;
        next_pslverr = next_pready & (~bus_on | ~mapped);
        next_prdata  = (next_pready && !pwrite && bus_on) ? rdata : 32'h0;
    end

    // reported mode follows the next state so it moves with o_rail_on
    always_comb begin
        if (next_mode == MODE_SLEEP) begin
            rep_mode = MODE_SLEEP;
        end else if (next_mode == MODE_ACTIVE && next_rails != 4'h0
                     && !fault) begin
            rep_mode = MODE_ACTIVE;
        end else begin
            rep_mode = MODE_STANDBY;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            seq_ord   <= SEQ_ORD_RESET;
            seq_dly   <= SEQ_DLY_RESET;
            int_stat  <= '0;
            int_mask  <= INT_MASK_RESET;
            cmd_stby  <= 1'b0;
            cmd_act   <= 1'b0;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            prdata    <= 32'h0000_0000;
            o_rail_on <= 4'h0;
            o_mode    <= MODE_SLEEP;
            o_irq     <= 1'b0;
        end else begin
            seq_ord   <= next_seq_ord;
            seq_dly   <= next_seq_dly;
            int_stat  <= next_int_stat;
            int_mask  <= next_int_mask;
            cmd_stby  <= next_cmd_stby;
            cmd_act   <= next_cmd_act;
            pready    <= next_pready;
            pslverr   <= next_pslverr;
            prdata    <= next_prdata;
            o_rail_on <= next_rails;
            o_mode    <= rep_mode;
            o_irq     <= |(next_int_stat & next_int_mask);
        end
    end

endmodule

/* File: rtl/pwr_mode_pkg.sv */
// shared constants and types of the power mode controller
package pwr_mode_pkg;

    // ---------------------------------------------------------------
    // modes and sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SLEEP   = 2'b00,
        MODE_STANDBY = 2'b01,
        MODE_ACTIVE  = 2'b10
    } mode_e;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_WAIT = 2'b01,
        SEQ_UP   = 2'b10,
        SEQ_DOWN = 2'b11
    } seq_e;

    typedef struct packed {
        logic thermal_shutdown_fault;
        logic inverting_undervoltage_fault;
        logic boost_undervoltage_fault;
        logic input_undervoltage_lockout;
    } fault_s;

    // ---------------------------------------------------------------
    // register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_SEQ_ORD  = 8'h04;
    localparam logic [7:0] ADDR_SEQ_DLY  = 8'h08;
    localparam logic [7:0] ADDR_STATUS   = 8'h0C;
    localparam logic [7:0] ADDR_INT_STAT = 8'h10;
    localparam logic [7:0] ADDR_INT_MASK = 8'h14;

    localparam int CTRL_STANDBY_BIT = 0;
    localparam int CTRL_ACTIVE_BIT  = 1;

    localparam int INT_FAULT_BIT = 0;
    localparam int INT_UP_BIT    = 1;
    localparam int INT_DOWN_BIT  = 2;
    localparam int INT_WIDTH     = 3;

    localparam logic [7:0] SEQ_ORD_RESET  = 8'hE4;
    localparam logic [7:0] SEQ_DLY_RESET  = 8'h0A;
    localparam logic [2:0] INT_MASK_RESET = 3'h0;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 50;
    localparam int WAKE_DELAY_NS     = 5500000;
    localparam int WAKE_DELAY_CYCLES =
        (WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLY_UNIT_NS       = 100000;
    localparam int DLY_UNIT_CYCLES   =
        (DLY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W           = 24;

endpackage

/* File: verification/host_model.sv */
// host side model driving the wake and rail enable pins
`timescale 1ns/1ps
module host_model #(
    parameter int MIN_LOW = 400
) (
    input  wire logic       i_clock,
    input  wire logic       i_req_wake,
    input  wire logic [3:0] i_req_pins,
    output logic            o_wake_input,
    output logic [3:0]      o_rail_enable_pins
);
    int low_count;
    initial begin
        o_wake_input       = 1'b0;
        o_rail_enable_pins = 4'h0;
        low_count          = 0;
    end
    // ---------------------------------------------------------------
    // pins follow the request; wake rises only after the low time
    // ---------------------------------------------------------------
    always @(posedge i_clock) begin
        o_rail_enable_pins <= i_req_pins;
        if (o_wake_input) begin
            low_count    <= 0;
            o_wake_input <= i_req_wake;
        end else if (low_count < MIN_LOW) begin
            low_count <= low_count + 1;
        end else begin
            o_wake_input <= i_req_wake;
        end
    end
endmodule

/* File: verification/pwr_mode_ctrl_sva.sv */
// assertions on the ports of the power mode controller
`timescale 1ns/1ps
module pwr_mode_ctrl_sva
    import pwr_mode_pkg::*;
(
    input wire logic       i_clock,
    input wire logic       i_rst_n,
    input wire logic       i_wake_input,
    input wire fault_s     i_fault,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic [3:0] o_rail_on,
    input wire logic [1:0] o_mode,
    input wire logic       o_irq
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    sequence access_start;
        psel && !penable ##1 psel && penable;
    endsequence
    a_mode_legal: assert property (o_mode != 2'b11)
        else $error("mode code out of range");
    a_active_rail: assert property (
        o_mode == MODE_ACTIVE |-> o_rail_on != 4'h0)
        else $error("active without a rail");
    a_standby_off: assert property (
        o_mode == MODE_STANDBY && i_fault == '0 |-> o_rail_on == 4'h0)
        else $error("rail on in standby");
    a_sleep_off: assert property (
        o_mode == MODE_SLEEP |-> o_rail_on == 4'h0)
        else $error("rail on in sleep");
    a_wake_sleep: assert property (
        $fell(i_wake_input) |-> ##[1:200] o_mode == MODE_SLEEP)
        else $error("no sleep after wake fall");
    a_standby_wake: assert property (
        $fell(i_wake_input) && o_mode == MODE_STANDBY
        |-> ##[1:8] o_mode == MODE_SLEEP)
        else $error("standby did not go to sleep");
    a_fault_standby: assert property (
        $rose(|i_fault) && i_wake_input
        |-> ##[1:200] o_mode == MODE_STANDBY)
        else $error("fault did not force standby");
    a_sleep_irq: assert property (
        (o_mode == MODE_SLEEP) [*2] |-> !o_irq)
        else $error("interrupt in sleep");
    a_sleep_refuse: assert property (
        psel && penable && pready && o_mode == MODE_SLEEP |-> pslverr)
        else $error("access accepted in sleep");
    a_ready_wait: assert property (access_start |=> pready)
        else $error("no answer after one wait state");
endmodule
bind pwr_mode_ctrl pwr_mode_ctrl_sva pwr_mode_ctrl_sva_i (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_wake_input(i_wake_input),
    .i_fault(i_fault), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .o_rail_on(o_rail_on), .o_mode(o_mode),
    .o_irq(o_irq));

/* File: verification/pwr_mode_ctrl_tb.sv */
// self-checking testbench of the power mode controller
`timescale 1ns/1ps
module pwr_mode_ctrl_tb
    import pwr_mode_pkg::*;
;
    logic i_clock, i_rst_n, req_wake, wake, psel, penable, pwrite;
    logic pready, pslverr, irq, errv;
    logic [3:0]  req_pins, pins, rail_on;
    logic [1:0]  mode;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdv;
    fault_s      fault;
    int          mismatches, check_count, n;

    host_model host_model_i (.i_clock(i_clock), .i_req_wake(req_wake),
        .i_req_pins(req_pins), .o_wake_input(wake),
        .o_rail_enable_pins(pins));
    pwr_mode_ctrl #(.WAKE_DELAY(20), .DLY_UNIT(4)) pwr_mode_ctrl_i (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_wake_input(wake),
        .i_rail_enable_pins(pins), .i_fault(fault), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .o_rail_on(rail_on), .o_mode(mode),
        .o_irq(irq));

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task check(input string name, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task final_report;
        if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task idle(input int c);
        repeat (c) @(posedge i_clock);
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a;
        pwdata <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge i_clock); n++; end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20) mismatches++;
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge i_clock);
    endtask
    // waits for the rails to change and compares the new pattern
    task step(input logic [3:0] exp);
        logic [3:0] prev;
        prev = rail_on;
        n = 0;
        while (rail_on === prev && n < 400) begin @(posedge i_clock); n++; end
        check("rails", rail_on, exp);
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task t_sleep;
        apb(1'b0, ADDR_SEQ_ORD, 32'h0);
        check("sleep err", errv, 1'b1);
        check("sleep data", rdv, 32'h0);
        check("sleep mode", mode, MODE_SLEEP);
    endtask
    task t_standby;
        req_wake <= 1'b1;
        idle(420);
        check("wake mode", mode, MODE_STANDBY);
        check("wake rails", rail_on, 4'h0);
        apb(1'b0, ADDR_SEQ_ORD, 32'h0);
        check("order reset", rdv, {24'h0, SEQ_ORD_RESET});
        apb(1'b0, ADDR_SEQ_DLY, 32'h0);
        check("delay reset", rdv, {24'h0, SEQ_DLY_RESET});
        apb(1'b0, 8'h18, 32'h0);
        check("unmapped err", errv, 1'b1);
    endtask
    task t_pins;
        req_pins <= 4'h4;
        step(4'h4);
        idle(2);
        check("pin mode", mode, MODE_ACTIVE);
        req_pins <= 4'h5;
        step(4'h5);
        req_pins <= 4'h1;
        step(4'h1);
        req_pins <= 4'h0;
        step(4'h0);
        idle(3);
        check("pins off mode", mode, MODE_STANDBY);
    endtask
    task t_cmd_up;
        apb(1'b1, ADDR_CTRL, 32'h2);
        step(4'h1);
        req_pins <= 4'h8;
        step(4'h3);
        req_pins <= 4'h0;
        step(4'h7);
        step(4'hF);
        idle(10);
        check("irq masked", irq, 1'b0);
        apb(1'b0, ADDR_INT_STAT, 32'h0);
        check("up done", rdv[INT_UP_BIT], 1'b1);
        apb(1'b1, ADDR_INT_MASK, 32'h2);
        idle(2);
        check("irq raised", irq, 1'b1);
        apb(1'b1, ADDR_INT_STAT, 32'h7);
        idle(2);
        check("irq cleared", irq, 1'b0);
    endtask
    task t_wake_down;
        req_wake <= 1'b0;
        step(4'h7);
        step(4'h3);
        step(4'h1);
        step(4'h0);
        idle(5);
        check("down mode", mode, MODE_SLEEP);
    endtask
    task t_wake_direct;
        req_pins <= 4'h1;
        req_wake <= 1'b1;
        n = 0;
        while (wake !== 1'b1 && n < 1000) begin @(posedge i_clock); n++; end
        n = 0;
        while (rail_on === 4'h0 && n < 200) begin @(posedge i_clock); n++; end
        check("start delay", n >= 20 && n <= 30, 1'b1);
        check("first rail", rail_on, 4'h1);
        step(4'h3);
        step(4'h7);
        step(4'hF);
    endtask
    task t_cmd_down;
        apb(1'b1, ADDR_CTRL, 32'h1);
        step(4'h7);
        step(4'h3);
        step(4'h1);
        step(4'h0);
        idle(3);
        check("cmd mode", mode, MODE_STANDBY);
    endtask
    task t_fault;
        req_pins <= 4'h3;
        step(4'h2);
        fault <= fault_s'(4'h2);
        req_pins <= 4'h7;
        step(4'h0);
        idle(3);
        check("fault mode", mode, MODE_STANDBY);
        req_pins <= 4'h0;
        idle(6);
        fault <= fault_s'(4'h0);
        req_wake <= 1'b0;
        idle(10);
        check("end mode", mode, MODE_SLEEP);
    endtask

    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end
    initial begin
        #2000000;
        mismatches++;
        final_report;
    end
    initial begin
        i_rst_n = 1'b0; req_wake = 1'b0; req_pins = 4'h0; fault = '0;
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0;
        pwdata = 32'h0; mismatches = 0; check_count = 0;
        idle(10);
        i_rst_n <= 1'b1;
        idle(3);
        t_sleep;
        t_standby;
        t_pins;
        t_cmd_up;
        t_wake_down;
        t_wake_direct;
        t_cmd_down;
        t_fault;
        final_report;
    end
endmodule
